// ### common/spl_pkg.sv
// Package: register map, strap layout and reset values for the strap link config block
package spl_pkg;
    localparam int NUM_PORTS = 2;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam int IDX_STRAP_STATUS = 0;
    localparam int IDX_LINK_CONFIG = 1;
    localparam int IDX_IRQ_STATUS = 187;
    localparam int IDX_IRQ_ENABLE = 188;
    localparam int IDX_LED_CTRL = 195;

    localparam logic [ADDR_W-1:0] ADDR_STRAP_STATUS = ADDR_W'(4 * IDX_STRAP_STATUS);
    localparam logic [ADDR_W-1:0] ADDR_LINK_CONFIG = ADDR_W'(4 * IDX_LINK_CONFIG);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'(4 * IDX_IRQ_STATUS);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = ADDR_W'(4 * IDX_IRQ_ENABLE);
    localparam logic [ADDR_W-1:0] ADDR_LED_CTRL = ADDR_W'(4 * IDX_LED_CTRL);

    // Strap vector layout: each field holds one bit per port
    localparam int STRAP_W = 8;
    localparam int STRAP_AN_LSB = 0;
    localparam int STRAP_SPD_LSB = 2;
    localparam int STRAP_DPX_LSB = 4;
    localparam int STRAP_FFC_LSB = 6;
    localparam int STRAP_DONE_BIT = 8;

    // Link config readback layout
    localparam int CFG_AN_LSB = 0;
    localparam int CFG_SPD_LSB = 2;
    localparam int CFG_DPX_LSB = 4;
    localparam int CFG_FC_LSB = 6;

    // Indicator mode field
    localparam int LED_MODE_LSB = 4;
    localparam int LED_MODE_W = 2;
    localparam logic [LED_MODE_W-1:0] LED_MODE_RESET = 2'h0;
    localparam logic [NUM_PORTS-1:0] IRQ_ENABLE_RESET = 2'h0;

    // Indicator modes
    typedef enum logic [1:0] {
        SPL_LED_SPEED_LINKACT = 2'h0,
        SPL_LED_ACT_LINK = 2'h1,
        SPL_LED_DUPLEX_LINKACT = 2'h2,
        SPL_LED_SPEED_LINK = 2'h3
    } spl_led_mode_e;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### src/spl_strap_cfg.sv
// Strap-driven link configuration, port 1 indicators, link-loss interrupt, AXI4-Lite registers
//
// What this block does
// RQ1: Port one autoneg follows strap, default off.
// RQ2: Port two autoneg follows its strap.
// RQ3: Port one forced 100 or 10 by strap.
// RQ4: Port two forced 100 or 10 by strap.
// RQ5: Port one duplex strap: fallback or forced.
// RQ6: Port two duplex strap: fallback or forced.
// RQ7: Port one flow strap high forces flow control.
// RQ8: Port two flow strap high forces flow control.
// RQ9: Default indicator mode: speed and link/activity.
// RQ10: Interrupt low while enabled link-loss bit set.
// RQ11: Straps latched at reset release, pins released.
`timescale 1ns/100ps
module spl_strap_cfg
    import spl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // Strap pins
    input wire logic port1_autoneg_strap,
    input wire logic port2_autoneg_strap,
    input wire logic port1_speed_strap,
    input wire logic port2_speed_strap,
    input wire logic port1_duplex_strap,
    input wire logic port2_duplex_strap,
    input wire logic port1_force_flowctl_strap,
    input wire logic port2_force_flowctl_strap,
    // PHY status, same clock
    input wire logic [NUM_PORTS-1:0] link_up,
    input wire logic [NUM_PORTS-1:0] link_activity,
    input wire logic [NUM_PORTS-1:0] an_failed,
    input wire logic [NUM_PORTS-1:0] an_speed_100,
    input wire logic [NUM_PORTS-1:0] an_full_duplex,
    input wire logic [NUM_PORTS-1:0] an_pause,
    // Resolved link configuration
    output logic [NUM_PORTS-1:0] autoneg_en,
    output logic [NUM_PORTS-1:0] speed_100,
    output logic [NUM_PORTS-1:0] full_duplex,
    output logic [NUM_PORTS-1:0] flowctl_en,
    output logic strap_release,
    // Port 1 indicators and interrupt
    output logic port1_link_act_indicator,
    output logic port1_link_act_indicator_oe,
    output logic port1_speed_indicator,
    output logic port1_speed_indicator_oe,
    output logic link_irq_n,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [STRAP_W-1:0] strap_pins;
    logic [STRAP_W-1:0] straps;
    logic strap_done;
    logic [NUM_PORTS-1:0] irq_status;
    logic [NUM_PORTS-1:0] irq_enable;
    logic [LED_MODE_W-1:0] led_mode;
    logic [NUM_PORTS-1:0] link_prev;
    logic [NUM_PORTS-1:0] link_lost;
    logic [NUM_PORTS-1:0] irq_read_clr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_lane0;
    logic aw_held;
    logic w_held;
    logic wr_fire;
    logic rd_fire;
    logic [NUM_PORTS-1:0] next_irq_status;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        addr_hit = (a[ADDR_W-1:2] == r[ADDR_W-1:2]);
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = addr_hit(a, ADDR_STRAP_STATUS) || addr_hit(a, ADDR_LINK_CONFIG)
            || addr_hit(a, ADDR_IRQ_STATUS) || addr_hit(a, ADDR_IRQ_ENABLE)
            || addr_hit(a, ADDR_LED_CTRL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture

    assign strap_pins = {port2_force_flowctl_strap, port1_force_flowctl_strap,
                         port2_duplex_strap, port1_duplex_strap,
                         port2_speed_strap, port1_speed_strap,
                         port2_autoneg_strap, port1_autoneg_strap};

    spl_strap_latch #(
        .W(STRAP_W)
    ) u_latch (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(strap_pins),
        .latched(straps),
        .done(strap_done)
    );

    // Shared pins go back to output use once straps are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_release <= 1'b0;
            port1_link_act_indicator_oe <= 1'b0;
            port1_speed_indicator_oe <= 1'b0;
        end else begin
            strap_release <= strap_done; // RQ11
            port1_link_act_indicator_oe <= strap_done; // RQ11
            port1_speed_indicator_oe <= strap_done; // RQ11
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-port link resolution

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic an_on;
        assign an_on = straps[STRAP_AN_LSB + p];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                autoneg_en[p] <= 1'b0;
                speed_100[p] <= 1'b0;
                full_duplex[p] <= 1'b0;
                flowctl_en[p] <= 1'b0;
            end else begin
                autoneg_en[p] <= an_on; // RQ1 RQ2
                if (an_on) begin
                    speed_100[p] <= an_speed_100[p];
                    // Duplex strap is the fallback when negotiation fails
                    full_duplex[p] <= an_failed[p] ? straps[STRAP_DPX_LSB + p] // RQ5 RQ6
                                                   : an_full_duplex[p];
                end else begin
                    speed_100[p] <= straps[STRAP_SPD_LSB + p]; // RQ3 RQ4
                    full_duplex[p] <= straps[STRAP_DPX_LSB + p]; // RQ5 RQ6
                end
                // Forced on, else only the negotiated pause result
                flowctl_en[p] <= straps[STRAP_FFC_LSB + p] // RQ7 RQ8
                    || (an_on && !an_failed[p] && an_pause[p]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port 1 indicators

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port1_link_act_indicator <= 1'b0;
            port1_speed_indicator <= 1'b0;
        end else begin
            case (spl_led_mode_e'(led_mode))
                SPL_LED_SPEED_LINKACT: begin
                    port1_link_act_indicator <= link_up[0] && !link_activity[0]; // RQ9
                    port1_speed_indicator <= speed_100[0]; // RQ9
                end
                SPL_LED_ACT_LINK: begin
                    port1_link_act_indicator <= link_up[0];
                    port1_speed_indicator <= link_activity[0];
                end
                SPL_LED_DUPLEX_LINKACT: begin
                    port1_link_act_indicator <= link_up[0] && !link_activity[0];
                    port1_speed_indicator <= full_duplex[0];
                end
                SPL_LED_SPEED_LINK: begin
                    port1_link_act_indicator <= link_up[0];
                    port1_speed_indicator <= speed_100[0];
                end
                default: begin
                    port1_link_act_indicator <= 1'b0;
                    port1_speed_indicator <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link-loss interrupt

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_prev <= '0;
        end else begin
            link_prev <= link_up;
        end
    end

    assign link_lost = link_prev & ~link_up;
    assign irq_read_clr = (rd_fire && addr_hit(s_axi_araddr, ADDR_IRQ_STATUS))
                          ? {NUM_PORTS{1'b1}} : '0;
    // New loss beats a read clear in the same cycle
    assign next_irq_status = (irq_status & ~irq_read_clr) | link_lost;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            link_irq_n <= 1'b1;
        end else begin
            irq_status <= next_irq_status;
            link_irq_n <= ~|(irq_status & irq_enable); // RQ10
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_lane0 <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_lane0 <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable <= IRQ_ENABLE_RESET;
            led_mode <= LED_MODE_RESET;
        end else if (wr_fire && wr_lane0) begin
            if (addr_hit(wr_addr, ADDR_IRQ_ENABLE)) begin
                irq_enable <= wr_data[NUM_PORTS-1:0];
            end
            if (addr_hit(wr_addr, ADDR_LED_CTRL)) begin
                led_mode <= wr_data[LED_MODE_LSB +: LED_MODE_W]; // RQ9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata <= '0;
                if (addr_hit(s_axi_araddr, ADDR_STRAP_STATUS)) begin
                    s_axi_rdata[STRAP_W-1:0] <= straps;
                    s_axi_rdata[STRAP_DONE_BIT] <= strap_done;
                end
                if (addr_hit(s_axi_araddr, ADDR_LINK_CONFIG)) begin
                    s_axi_rdata[CFG_AN_LSB +: NUM_PORTS] <= autoneg_en;
                    s_axi_rdata[CFG_SPD_LSB +: NUM_PORTS] <= speed_100;
                    s_axi_rdata[CFG_DPX_LSB +: NUM_PORTS] <= full_duplex;
                    s_axi_rdata[CFG_FC_LSB +: NUM_PORTS] <= flowctl_en;
                end
                if (addr_hit(s_axi_araddr, ADDR_IRQ_STATUS)) begin
                    s_axi_rdata[NUM_PORTS-1:0] <= irq_status;
                end
                if (addr_hit(s_axi_araddr, ADDR_IRQ_ENABLE)) begin
                    s_axi_rdata[NUM_PORTS-1:0] <= irq_enable;
                end
                if (addr_hit(s_axi_araddr, ADDR_LED_CTRL)) begin
                    s_axi_rdata[LED_MODE_LSB +: LED_MODE_W] <= led_mode;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_held;
        strap_done ##1 strap_done;
    endsequence

    sequence s_link_drop(p);
        link_up[p] ##1 !link_up[p];
    endsequence

    chk_an_port_one: assert property (s_held |-> autoneg_en[0] == straps[STRAP_AN_LSB]) // RQ1
        else $error("port 1 autoneg differs from strap");
    chk_an_port_two: assert property (s_held |-> autoneg_en[1] == straps[STRAP_AN_LSB + 1]) // RQ2
        else $error("port 2 autoneg differs from strap");
    chk_speed_port_one: assert property ( // RQ3
        strap_done && !straps[STRAP_AN_LSB] |=> speed_100[0] == $past(straps[STRAP_SPD_LSB]))
        else $error("port 1 forced speed wrong");
    chk_speed_port_two: assert property ( // RQ4
        strap_done && !straps[STRAP_AN_LSB + 1] |=> speed_100[1] == straps[STRAP_SPD_LSB + 1])
        else $error("port 2 forced speed wrong");
    chk_duplex_port_one: assert property ( // RQ5
        strap_done && (!straps[STRAP_AN_LSB] || an_failed[0])
        |=> full_duplex[0] == straps[STRAP_DPX_LSB])
        else $error("port 1 duplex strap not applied");
    chk_duplex_port_two: assert property ( // RQ6
        strap_done && (!straps[STRAP_AN_LSB + 1] || an_failed[1])
        |=> full_duplex[1] == straps[STRAP_DPX_LSB + 1])
        else $error("port 2 duplex strap not applied");
    chk_flow_port_one: assert property (s_held |-> !straps[STRAP_FFC_LSB] || flowctl_en[0]) // RQ7
        else $error("port 1 flow control not forced");
    chk_flow_port_two: assert property ( // RQ8
        strap_done && !straps[STRAP_FFC_LSB + 1] && !straps[STRAP_AN_LSB + 1]
        |=> !flowctl_en[1])
        else $error("port 2 flow control on without cause");
    chk_led_default: assert property ( // RQ9
        aresetn && led_mode == LED_MODE_RESET |=> port1_speed_indicator == $past(speed_100[0])
            && port1_link_act_indicator == $past(link_up[0] && !link_activity[0]))
        else $error("default indicator mode wrong");
    chk_irq_level: assert property ( // RQ10
        |(irq_status & irq_enable) |=> !link_irq_n)
        else $error("interrupt not asserted");
    chk_irq_loss: assert property (s_link_drop(0) |=> irq_status[0] ##1 !link_irq_n[*1] // RQ10
        or (irq_status[0] && !irq_enable[0]))
        else $error("link loss not recorded");
    chk_strap_frozen: assert property (s_held |-> $stable(straps) && strap_release) // RQ11
        else $error("straps changed after capture");
endmodule

// ### src/spl_strap_latch.sv
// Strap pin synchroniser and one-time capture at reset release
`timescale 1ns/100ps
module spl_strap_latch
    import spl_pkg::*;
#(
    parameter int W = STRAP_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] latched,
    output logic done
);
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;

    // Synchroniser keeps running through reset so the level is settled at release
    always_ff @(posedge aclk) begin
        sync1 <= pins;
        sync2 <= sync1;
    end

    // Capture once on the first edge after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done <= 1'b0;
            latched <= '0;
        end else if (!done) begin
            done <= 1'b1; // RQ11
            latched <= sync2; // RQ11
        end
    end
endmodule

// ### test/spl_board_model.sv
// Board strap resistors seen by the strap pins
`timescale 1ns/100ps
module spl_board_model (
    input wire logic [7:0] pull_up,
    output logic port1_autoneg_strap,
    output logic port2_autoneg_strap,
    output logic port1_speed_strap,
    output logic port2_speed_strap,
    output logic port1_duplex_strap,
    output logic port2_duplex_strap,
    output logic port1_force_flowctl_strap,
    output logic port2_force_flowctl_strap
);
    // Bit clear means a pull-down or no resistor fitted
    assign {port2_force_flowctl_strap, port1_force_flowctl_strap} = pull_up[7:6];
    assign {port2_duplex_strap, port1_duplex_strap} = pull_up[5:4];
    assign {port2_speed_strap, port1_speed_strap} = pull_up[3:2];
    assign {port2_autoneg_strap, port1_autoneg_strap} = pull_up[1:0];
endmodule

// ### test/spl_strap_cfg_tb.sv
// Self-checking testbench for the strap link configuration block
`timescale 1ns/100ps
module spl_strap_cfg_tb;
    import spl_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] strap_set = 8'h00;
    logic [7:0] lfsr = 8'h5A;
    logic [NUM_PORTS-1:0] link_up = '0, link_activity = '0, an_failed = '0;
    logic [NUM_PORTS-1:0] an_speed_100 = '0, an_full_duplex = '0, an_pause = '0;
    logic [NUM_PORTS-1:0] autoneg_en, speed_100, full_duplex, flowctl_en;
    logic p1an, p2an, p1sp, p2sp, p1dx, p2dx, p1fc, p2fc;
    logic strap_release, li_act, li_act_oe, li_spd, li_spd_oe, link_irq_n;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [DATA_W-1:0] rdata;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #4 aclk = ~aclk;

    spl_board_model board (.pull_up(strap_set), .port1_autoneg_strap(p1an),
        .port2_autoneg_strap(p2an), .port1_speed_strap(p1sp), .port2_speed_strap(p2sp),
        .port1_duplex_strap(p1dx), .port2_duplex_strap(p2dx),
        .port1_force_flowctl_strap(p1fc), .port2_force_flowctl_strap(p2fc));

    spl_strap_cfg DUT (.aclk(aclk), .aresetn(aresetn), .port1_autoneg_strap(p1an),
        .port2_autoneg_strap(p2an), .port1_speed_strap(p1sp), .port2_speed_strap(p2sp),
        .port1_duplex_strap(p1dx), .port2_duplex_strap(p2dx),
        .port1_force_flowctl_strap(p1fc), .port2_force_flowctl_strap(p2fc),
        .link_up(link_up), .link_activity(link_activity), .an_failed(an_failed),
        .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex), .an_pause(an_pause),
        .autoneg_en(autoneg_en), .speed_100(speed_100), .full_duplex(full_duplex),
        .flowctl_en(flowctl_en), .strap_release(strap_release),
        .port1_link_act_indicator(li_act), .port1_link_act_indicator_oe(li_act_oe),
        .port1_speed_indicator(li_spd), .port1_speed_indicator_oe(li_spd_oe),
        .link_irq_n(link_irq_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr_step(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    // Resolved config in link config layout, from latched straps and PHY state
    function automatic logic [7:0] exp_cfg(input logic [7:0] s);
        logic [7:0] c;
        c = 8'h00;
        for (int p = 0; p < 2; p++) begin
            c[CFG_AN_LSB+p] = s[STRAP_AN_LSB+p];
            c[CFG_SPD_LSB+p] = s[STRAP_AN_LSB+p] ? an_speed_100[p] : s[STRAP_SPD_LSB+p];
            c[CFG_DPX_LSB+p] = (s[STRAP_AN_LSB+p] && !an_failed[p]) ? an_full_duplex[p]
                : s[STRAP_DPX_LSB+p];
            c[CFG_FC_LSB+p] = s[STRAP_FFC_LSB+p]
                | (s[STRAP_AN_LSB+p] & !an_failed[p] & an_pause[p]);
        end
        return c;
    endfunction

    task automatic close_out;
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
            output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic phy_rand;
        lfsr = lfsr_step(lfsr);
        {an_failed, an_speed_100, an_full_duplex, an_pause} <= lfsr;
        lfsr = lfsr_step(lfsr);
        {link_up, link_activity} <= lfsr[3:0];
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] s;
        logic [7:0] e;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_step(lfsr);
            s = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lfsr;
            @(posedge aclk);
            aresetn <= 1'b0;
            strap_set <= s;
            repeat (20) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (3) @(posedge aclk);
            check(32'({strap_release, li_act_oe, li_spd_oe}), 32'h7);
            for (int j = 0; j < 4; j++) begin
                phy_rand();
                repeat (3) @(posedge aclk);
                check(32'({flowctl_en, full_duplex, speed_100, autoneg_en}), 32'(exp_cfg(s)));
            end
            axi_read(ADDR_STRAP_STATUS, d, r);
            check(d, {23'h0, 1'b1, s});
            axi_read(ADDR_LINK_CONFIG, d, r);
            check(d, 32'(exp_cfg(s)));
            strap_set <= ~s;
            repeat (4) @(posedge aclk);
            check(32'({flowctl_en, full_duplex, speed_100, autoneg_en}), 32'(exp_cfg(s)));
        end
        // Indicator modes, reset mode first
        axi_read(ADDR_LED_CTRL, d, r);
        check(d, 32'h0);
        for (int m = 0; m < 4; m++) begin
            if (m > 0) axi_write(ADDR_LED_CTRL, 32'(m) << LED_MODE_LSB, r);
            phy_rand();
            repeat (4) @(posedge aclk);
            e = exp_cfg(s);
            d[1] = (m == 1) ? link_activity[0] : (m == 2) ? e[CFG_DPX_LSB] : e[CFG_SPD_LSB];
            d[0] = (m % 2 == 1) ? link_up[0] : (link_up[0] & !link_activity[0]);
            check(32'({li_spd, li_act}), 32'(d[1:0]));
        end
        // Link loss interrupt, port two masked
        axi_write(ADDR_IRQ_ENABLE, 32'h1, r);
        check(32'(r), 32'(RESP_OKAY));
        link_up <= 2'b11;
        repeat (3) @(posedge aclk);
        axi_read(ADDR_IRQ_STATUS, d, r);
        repeat (2) @(posedge aclk);
        check(32'(link_irq_n), 32'h1);
        link_up <= 2'b10;
        repeat (4) @(posedge aclk);
        check(32'(link_irq_n), 32'h0);
        axi_read(ADDR_IRQ_STATUS, d, r);
        check(d, 32'h1);
        repeat (2) @(posedge aclk);
        check(32'(link_irq_n), 32'h1);
        link_up <= 2'b00;
        repeat (4) @(posedge aclk);
        check(32'(link_irq_n), 32'h1);
        axi_read(ADDR_IRQ_STATUS, d, r);
        check(d, 32'h2);
        axi_read(ADDR_IRQ_ENABLE, d, r);
        check(d, 32'h1);
        check(32'(r), 32'(RESP_OKAY));
        // Unmapped place and read-only register
        axi_read(12'h100, d, r);
        check({d[29:0], r}, {30'h0, RESP_SLVERR});
        axi_write(12'h100, 32'hFFFF_FFFF, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_write(ADDR_STRAP_STATUS, 32'h0, r);
        axi_read(ADDR_STRAP_STATUS, d, r);
        check(d, {23'h0, 1'b1, s});
        close_out();
    end
endmodule
